/* File: fscp_flash_regs.sv */
// status and configuration register core of a serial flash, with protection
// Notes on behaviour
// - guard 00: write needs latch, pin ignored
// - guard 01, pin low: refuse status writes
// - guard 01, pin high: write with latch
// - guard 10: refuse until power cycle clears
// - guard 11: status register locked until power cycle clears
// - quad enable turns guard/pause pins data
// - failed, aborted or blocked operation sets fail
// - next success clears fail, never stalls
// - lock bits set singly, cleared only by power cycle
// - invert bit stored, default zero, exported
// - suspend command sets suspend flag
// - resume, reset pair or power clear suspend
// - page select zero 256, one 1024
// - buffer offset wraps at selected page size
// - page erase covers selected page size
// - drive field selects output drive level
// - dual read dummy cycles 4 or 8
// - quad read dummy cycles 6 or 10
// - latch clear: ignore writes, program, erase
// - quad commands only with quad enable
`timescale 1ns/1ps
`default_nettype none
module fscp_flash_regs
  import fscp_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_si,
  input wire logic i_wp_n,
  input wire logic i_busy,
  input wire logic i_pe_done,
  input wire logic i_pe_ok,
  input wire logic i_pe_abort,
  input wire logic i_pe_blocked,
  output logic o_so,
  output logic o_so_oe,
  output logic [15:0] o_status_word,
  output logic [7:0] o_config_word,
  output logic o_quad_io_enable,
  output logic o_wp_pin_active,
  output logic o_hold_pin_active,
  output logic [4:0] o_array_guard_bits,
  output logic o_protect_invert,
  output logic [2:0] o_secreg_lock,
  output logic o_suspended,
  output logic [9:0] o_page_wrap_mask,
  output logic [6:0] o_drive_pct,
  output logic [3:0] o_dummy_dual,
  output logic [3:0] o_dummy_quad,
  output logic o_pe_req,
  output logic [7:0] o_pe_opcode,
  output logic o_quad_cmd,
  output logic o_cmd_refused
);
  // all core state
  typedef struct packed {
    logic [SYNC_W-1:0] s1; // first synchroniser stage
    logic [SYNC_W-1:0] s2; // second synchroniser stage
    logic cs_prev; // chip select seen last cycle
    logic ph_prev; // phase seen last cycle
    logic pend; // byte waiting to be taken
    logic end_go; // frame ended, execute now
    logic [2:0] nbytes; // bytes in frame, saturating
    logic [7:0] opcode; // first byte of the frame
    logic [2:0][7:0] dat; // data bytes after the opcode
    logic rst_armed; // last frame was the reset arm
    logic write_latch_flag; // write_latch_flag
    logic [1:0] guard; // {sreg_guard_hi, sreg_guard_lo}
    logic [4:0] bp; // array_guard_bits
    logic qe; // quad_io_enable
    logic fail; // pe_error_flag
    logic [2:0] locks; // secreg_lock_3..1
    logic inv; // protect_invert
    logic sus; // suspend flag
    logic page_wide; // wide_page_select
    logic [1:0] drv; // {drive_strength_hi, drive_strength_lo}
    logic dc; // dummy_cycle_select
    logic [23:0] mirror; // read-back copy for the front end
    logic [15:0] stat; // status word output
    logic [7:0] cfg; // config word output
    logic wp_act; // guard pin keeps its function
    logic [9:0] mask; // program buffer offset mask
    logic [6:0] pct; // drive level in percent
    logic [3:0] dum_dual; // dual i/o read latency
    logic [3:0] dum_quad; // quad i/o read latency
    logic pe_req; // program or erase accepted
    logic [7:0] pe_op; // its opcode
    logic quad_cmd; // quad command accepted
    logic refused; // command refused
  } fscp_core_s;

  fscp_core_s q_r;
  fscp_core_s q_nxt;
  fscp_link_if lnk();
  logic cs_s;
  logic ph_s;
  logic wp_s;
  logic [7:0] byte_s;
  logic wp_eff;
  logic wr_ok;

  // serial clock domain front end
  fscp_spi_front u_front (
    .i_sclk(i_sclk),
    .i_cs_n(i_cs_n),
    .i_si(i_si),
    .o_so(o_so),
    .o_so_oe(o_so_oe),
    .lnk(lnk.front)
  );

  // quad-width opcodes
  function automatic logic is_quad(input logic [7:0] op);
    is_quad = (op == OP_QREAD_OUT) || (op == OP_QREAD_IO) || (op == OP_QREAD_WORD) ||
              (op == OP_QREAD_OCT) || (op == OP_QREAD_ID) || (op == OP_PROG_QUAD);
  endfunction

  // program and erase opcodes
  function automatic logic is_pe(input logic [7:0] op);
    is_pe = (op == OP_PROG) || (op == OP_PROG_DUAL) || (op == OP_PROG_QUAD) ||
            (op == OP_PAGE_ERASE) || (op == OP_SECT_ERASE) || (op == OP_HALF_ERASE) ||
            (op == OP_BLK_ERASE) || (op == OP_CHIP_ERASE_A) || (op == OP_CHIP_ERASE_B);
  endfunction

  // synchronised views of the pins and the byte carrier
  assign cs_s = q_r.s2[IDX_CS];
  assign ph_s = q_r.s2[IDX_PH];
  assign wp_s = q_r.s2[IDX_WP];
  assign byte_s = q_r.s2[7:0];
  // with quad enable set the guard pin is a data line, so it reads as high
  assign wp_eff = q_r.qe | wp_s;
  // status write permission from guard mode, pin and latch
  assign wr_ok = q_r.write_latch_flag && ((q_r.guard == GUARD_SW) || ((q_r.guard == GUARD_HW) && wp_eff));

  // next core state
  always_comb begin
    q_nxt = q_r;
    q_nxt.s1 = {i_cs_n, i_wp_n, lnk.rx_phase, lnk.rx_byte};
    q_nxt.s2 = q_r.s1;
    q_nxt.cs_prev = cs_s;
    q_nxt.ph_prev = ph_s;
    q_nxt.pe_req = 1'b0;
    q_nxt.quad_cmd = 1'b0;
    q_nxt.refused = 1'b0;
    // a new frame starts with no bytes
    if (!cs_s && q_r.cs_prev) begin
      q_nxt.nbytes = 3'h0;
    end
    // a byte event; the byte itself is taken one cycle later to let it settle
    q_nxt.pend = !cs_s && (ph_s != q_r.ph_prev);
    if (q_r.pend) begin
      if (q_r.nbytes == 3'h0) begin
        q_nxt.opcode = byte_s;
        if (is_quad(byte_s)) begin
          q_nxt.quad_cmd = q_r.qe;
          q_nxt.refused = ~q_r.qe;
        end
      end else if (q_r.nbytes != NBYTES_MAX) begin
        q_nxt.dat[q_r.nbytes - 3'h1] = byte_s;
      end
      if (q_r.nbytes != NBYTES_MAX) begin
        q_nxt.nbytes = q_r.nbytes + 3'h1;
      end
    end
    // execute one cycle after the frame end so the last byte is in
    q_nxt.end_go = cs_s && !q_r.cs_prev && (q_r.nbytes != 3'h0);
    if (q_r.end_go) begin
      q_nxt.rst_armed = (q_r.opcode == OP_RESET_ARM);
      case (q_r.opcode)
        OP_WR_ENABLE: begin
          q_nxt.write_latch_flag = 1'b1;
        end
        OP_WR_DISABLE: begin
          q_nxt.write_latch_flag = 1'b0;
        end
        OP_STAT_WRITE: begin
          if (q_r.nbytes >= 3'h2) begin
            if (wr_ok) begin
              q_nxt.bp = q_r.dat[0][SB_GUARD_LO-1:SB_BP_LO];
              q_nxt.guard[0] = q_r.dat[0][SB_GUARD_LO];
              if (q_r.nbytes >= 3'h3) begin
                q_nxt.guard[1] = q_r.dat[1][SB_GUARD_HI-8];
                q_nxt.qe = q_r.dat[1][SB_QE-8];
                q_nxt.locks = q_r.locks | q_r.dat[1][SB_INV-9:SB_LOCK_LO-8];
                q_nxt.inv = q_r.dat[1][SB_INV-8];
              end
              if (q_r.nbytes == NBYTES_MAX) begin
                q_nxt.dc = q_r.dat[2][CB_DC];
                q_nxt.page_wide = q_r.dat[2][CB_PAGE];
                q_nxt.drv = q_r.dat[2][CB_DRV_LO+1:CB_DRV_LO];
              end
            end else begin
              q_nxt.refused = 1'b1;
            end
            q_nxt.write_latch_flag = 1'b0;
          end
        end
        OP_STAT_WRITE_HI: begin
          if (q_r.nbytes >= 3'h2) begin
            if (wr_ok) begin
              q_nxt.guard[1] = q_r.dat[0][SB_GUARD_HI-8];
              q_nxt.qe = q_r.dat[0][SB_QE-8];
              q_nxt.locks = q_r.locks | q_r.dat[0][SB_INV-9:SB_LOCK_LO-8];
              q_nxt.inv = q_r.dat[0][SB_INV-8];
            end else begin
              q_nxt.refused = 1'b1;
            end
            q_nxt.write_latch_flag = 1'b0;
          end
        end
        OP_SUSPEND_A, OP_SUSPEND_B: begin
          q_nxt.sus = 1'b1;
        end
        OP_RESUME_A, OP_RESUME_B: begin
          q_nxt.sus = 1'b0;
        end
        OP_RESET_GO: begin
          if (q_r.rst_armed) begin
            q_nxt.sus = 1'b0;
            q_nxt.write_latch_flag = 1'b0;
          end
        end
        default: begin
          if (is_pe(q_r.opcode)) begin
            if (q_r.write_latch_flag && (q_r.qe || (q_r.opcode != OP_PROG_QUAD))) begin
              q_nxt.pe_req = 1'b1;
              q_nxt.pe_op = q_r.opcode;
              q_nxt.write_latch_flag = 1'b0;
            end else begin
              q_nxt.refused = 1'b1;
            end
          end
        end
      endcase
    end
    if (i_pe_done && i_pe_ok) begin
      q_nxt.fail = 1'b0;
    end
    if ((i_pe_done && !i_pe_ok) || i_pe_abort || i_pe_blocked) begin
      q_nxt.fail = 1'b1;
    end
    // outputs and read-back built from the next state
    q_nxt.stat = {q_nxt.sus, q_nxt.inv, q_nxt.locks, q_nxt.fail, q_nxt.qe, q_nxt.guard,
                  q_nxt.bp, q_nxt.write_latch_flag, i_busy};
    q_nxt.cfg = {1'b0, q_nxt.drv, q_nxt.page_wide, 3'h0, q_nxt.dc};
    if (cs_s) begin
      q_nxt.mirror = {q_nxt.cfg, q_nxt.stat};
    end
    q_nxt.wp_act = ~q_nxt.qe;
    q_nxt.mask = q_nxt.page_wide ? PAGE_MASK_WIDE : PAGE_MASK_SMALL;
    case (q_nxt.drv)
      2'h0: q_nxt.pct = DRV_PCT_00;
      2'h1: q_nxt.pct = DRV_PCT_01;
      2'h2: q_nxt.pct = DRV_PCT_10;
      default: q_nxt.pct = DRV_PCT_11;
    endcase
    q_nxt.dum_dual = q_nxt.dc ? DUMMY_DUAL_FAST : DUMMY_DUAL_STD;
    q_nxt.dum_quad = q_nxt.dc ? DUMMY_QUAD_FAST : DUMMY_QUAD_STD;
  end

  // core register; reset stands for a power cycle
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      q_r <= '0;
      q_r.s1 <= {1'b1, 1'b1, 9'h000};
      q_r.s2 <= {1'b1, 1'b1, 9'h000};
      q_r.cs_prev <= 1'b1;
      q_r.guard <= GUARD_SW;
      q_r.bp <= RST_BP;
      q_r.locks <= RST_LOCKS;
      q_r.drv <= RST_DRV;
      q_r.stat <= 16'h0000;
      q_r.cfg <= {1'b0, RST_DRV, 5'h00};
      q_r.mirror <= {1'b0, RST_DRV, 21'h000000};
      q_r.wp_act <= 1'b1;
      q_r.mask <= PAGE_MASK_SMALL;
      q_r.pct <= DRV_PCT_11;
      q_r.dum_dual <= DUMMY_DUAL_STD;
      q_r.dum_quad <= DUMMY_QUAD_STD;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign lnk.mirror = q_r.mirror;
  assign o_status_word = q_r.stat;
  assign o_config_word = q_r.cfg;
  assign o_quad_io_enable = q_r.stat[SB_QE];
  assign o_wp_pin_active = q_r.wp_act;
  assign o_hold_pin_active = q_r.wp_act;
  assign o_array_guard_bits = q_r.stat[SB_GUARD_LO-1:SB_BP_LO];
  assign o_protect_invert = q_r.stat[SB_INV];
  assign o_secreg_lock = q_r.stat[SB_INV-1:SB_LOCK_LO];
  assign o_suspended = q_r.stat[SB_SUS];
  assign o_page_wrap_mask = q_r.mask;
  assign o_drive_pct = q_r.pct;
  assign o_dummy_dual = q_r.dum_dual;
  assign o_dummy_quad = q_r.dum_quad;
  assign o_pe_req = q_r.pe_req;
  assign o_pe_opcode = q_r.pe_op;
  assign o_quad_cmd = q_r.quad_cmd;
  assign o_cmd_refused = q_r.refused;

  AST_SW_NEEDS_LATCH: assert property (@(posedge i_mclk) disable iff (i_rst)
    (q_r.end_go && q_r.opcode == OP_STAT_WRITE && !q_r.write_latch_flag) |=> $stable(q_r.bp) && $stable(q_r.guard))
    else $error("status write took effect without write latch");
  AST_HW_PIN_LOW: assert property (@(posedge i_mclk) disable iff (i_rst)
    (q_r.end_go && q_r.opcode == OP_STAT_WRITE && q_r.nbytes >= 3'h2 && q_r.guard == GUARD_HW && !wp_eff)
    |=> $stable(q_r.bp) && o_cmd_refused)
    else $error("status write not refused with guard pin low");
  AST_HW_PIN_HIGH: assert property (@(posedge i_mclk) disable iff (i_rst)
    (q_r.end_go && q_r.opcode == OP_STAT_WRITE && q_r.nbytes >= 3'h2 && q_r.guard == GUARD_HW && wp_eff && q_r.write_latch_flag)
    |=> q_r.bp == $past(q_r.dat[0][SB_GUARD_LO-1:SB_BP_LO]) ##1 o_array_guard_bits == $past(q_r.bp))
    else $error("status write not applied with guard pin high");
  AST_LOCKDOWN_HOLDS: assert property (@(posedge i_mclk) disable iff (i_rst)
    (q_r.guard == GUARD_LOCKDOWN) |=> (q_r.guard == GUARD_LOCKDOWN) && $stable(q_r.qe))
    else $error("lockdown guard mode left without power cycle");
  AST_OTP_HOLDS: assert property (@(posedge i_mclk) disable iff (i_rst)
    (q_r.guard == GUARD_OTP) |=> $stable(q_r.guard) && $stable(q_r.bp) && $stable(q_r.inv))
    else $error("one-time locked status register changed");
  AST_QUAD_PINS: assert property (@(posedge i_mclk) disable iff (i_rst)
    o_quad_io_enable |-> !o_wp_pin_active && !o_hold_pin_active)
    else $error("guard pin still active with quad enable");
  AST_FAIL_SET: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_pe_done && !i_pe_ok) |=> q_r.fail ##1 o_status_word[SB_FAIL])
    else $error("fail flag not set after failed operation");
  AST_FAIL_CLEAR: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_pe_done && i_pe_ok && !i_pe_abort && !i_pe_blocked) |=> ##1 !o_status_word[SB_FAIL])
    else $error("fail flag not cleared after success");
  AST_LOCKS_STICK: assert property (@(posedge i_mclk) disable iff (i_rst)
    ((q_r.locks & $past(q_r.locks)) == $past(q_r.locks)))
    else $error("security lock bit returned to zero");
  AST_SUSPEND_SET: assert property (@(posedge i_mclk) disable iff (i_rst)
    (q_r.end_go && (q_r.opcode == OP_SUSPEND_A || q_r.opcode == OP_SUSPEND_B)) |=> ##1 o_suspended)
    else $error("suspend flag not set");
  AST_SUSPEND_CLEAR: assert property (@(posedge i_mclk) disable iff (i_rst)
    (q_r.end_go && (q_r.opcode == OP_RESUME_A || q_r.opcode == OP_RESUME_B ||
      (q_r.opcode == OP_RESET_GO && q_r.rst_armed)))
    |=> ##1 !o_suspended)
    else $error("suspend flag not cleared");
  AST_PAGE_MASK: assert property (@(posedge i_mclk) disable iff (i_rst)
    $rose(q_r.page_wide) |-> o_page_wrap_mask == PAGE_MASK_WIDE)
    else $error("page mask does not follow page select");
  AST_DUMMY_QUAD: assert property (@(posedge i_mclk) disable iff (i_rst)
    $fell(q_r.dc) |-> o_dummy_quad == DUMMY_QUAD_STD && o_dummy_dual == DUMMY_DUAL_STD)
    else $error("read latency does not follow dummy select");
  AST_PE_NEEDS_LATCH: assert property (@(posedge i_mclk) disable iff (i_rst)
    (q_r.end_go && is_pe(q_r.opcode) && !q_r.write_latch_flag) |=> !o_pe_req && o_cmd_refused)
    else $error("program or erase accepted without latch");
endmodule
`default_nettype wire

/* File: fscp_pkg.sv */
// shared constants for the flash status and configuration register bank
package fscp_pkg;
  // command codes seen on the serial link
  localparam logic [7:0] OP_WR_ENABLE = 8'h06;
  localparam logic [7:0] OP_WR_DISABLE = 8'h04;
  localparam logic [7:0] OP_STAT_WRITE = 8'h01;
  localparam logic [7:0] OP_STAT_WRITE_HI = 8'h31;
  localparam logic [7:0] OP_READ_LO = 8'h05;
  localparam logic [7:0] OP_READ_HI = 8'h35;
  localparam logic [7:0] OP_READ_CFG = 8'h15;
  localparam logic [7:0] OP_SUSPEND_A = 8'h75;
  localparam logic [7:0] OP_SUSPEND_B = 8'hb0;
  localparam logic [7:0] OP_RESUME_A = 8'h7a;
  localparam logic [7:0] OP_RESUME_B = 8'h30;
  localparam logic [7:0] OP_RESET_ARM = 8'h66;
  localparam logic [7:0] OP_RESET_GO = 8'h99;
  localparam logic [7:0] OP_PAGE_ERASE = 8'h81;
  localparam logic [7:0] OP_PROG = 8'h02;
  localparam logic [7:0] OP_PROG_DUAL = 8'ha2;
  localparam logic [7:0] OP_PROG_QUAD = 8'h32;
  localparam logic [7:0] OP_SECT_ERASE = 8'h20;
  localparam logic [7:0] OP_HALF_ERASE = 8'h52;
  localparam logic [7:0] OP_BLK_ERASE = 8'hd8;
  localparam logic [7:0] OP_CHIP_ERASE_A = 8'h60;
  localparam logic [7:0] OP_CHIP_ERASE_B = 8'hc7;
  localparam logic [7:0] OP_QREAD_OUT = 8'h6b;
  localparam logic [7:0] OP_QREAD_IO = 8'heb;
  localparam logic [7:0] OP_QREAD_WORD = 8'he7;
  localparam logic [7:0] OP_QREAD_OCT = 8'he3;
  localparam logic [7:0] OP_QREAD_ID = 8'h94;
  // status word field positions
  localparam int SB_BUSY = 0;
  localparam int SB_WEL = 1;
  localparam int SB_BP_LO = 2;
  localparam int SB_GUARD_LO = 7;
  localparam int SB_GUARD_HI = 8;
  localparam int SB_QE = 9;
  localparam int SB_FAIL = 10;
  localparam int SB_LOCK_LO = 11;
  localparam int SB_INV = 14;
  localparam int SB_SUS = 15;
  // configuration word field positions
  localparam int CB_DC = 0;
  localparam int CB_PAGE = 4;
  localparam int CB_DRV_LO = 5;
  // guard modes held in the two guard bits
  localparam logic [1:0] GUARD_SW = 2'h0;
  localparam logic [1:0] GUARD_HW = 2'h1;
  localparam logic [1:0] GUARD_LOCKDOWN = 2'h2;
  localparam logic [1:0] GUARD_OTP = 2'h3;
  // power-up values of the stored fields
  localparam logic [4:0] RST_BP = 5'h00;
  localparam logic [2:0] RST_LOCKS = 3'h0;
  localparam logic [1:0] RST_DRV = 2'h3;
  // drive strength in percent per code
  localparam logic [6:0] DRV_PCT_00 = 7'h50;
  localparam logic [6:0] DRV_PCT_01 = 7'h28;
  localparam logic [6:0] DRV_PCT_10 = 7'h64;
  localparam logic [6:0] DRV_PCT_11 = 7'h3c;
  // dummy cycles for dual and quad i/o reads
  localparam logic [3:0] DUMMY_DUAL_STD = 4'h4;
  localparam logic [3:0] DUMMY_DUAL_FAST = 4'h8;
  localparam logic [3:0] DUMMY_QUAD_STD = 4'h6;
  localparam logic [3:0] DUMMY_QUAD_FAST = 4'ha;
  // program buffer offset masks
  localparam logic [9:0] PAGE_MASK_SMALL = 10'h0ff;
  localparam logic [9:0] PAGE_MASK_WIDE = 10'h3ff;
  // link framing
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] NBYTES_MAX = 3'h4;
  localparam int SYNC_W = 11;
  localparam int IDX_PH = 8;
  localparam int IDX_WP = 9;
  localparam int IDX_CS = 10;
endpackage

/* File: fscp_link_if.sv */
// byte and read-back carrier between serial front end and register core
`timescale 1ns/1ps
`default_nettype none
interface fscp_link_if;
  logic [7:0] rx_byte; // last completed byte of the frame
  logic rx_phase; // flips once per completed byte
  logic [23:0] mirror; // {config, status} frozen while a frame runs
  modport front (output rx_byte, output rx_phase, input mirror);
  modport core (input rx_byte, input rx_phase, output mirror);
endinterface
`default_nettype wire

/* File: fscp_spi_front.sv */
// serial clock domain front end: shifts bytes in and register bytes out
`timescale 1ns/1ps
`default_nettype none
module fscp_spi_front
  import fscp_pkg::*;
(
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_si,
  output logic o_so,
  output logic o_so_oe,
  fscp_link_if.front lnk
);
  // whole frame state, cleared while chip select is high
  typedef struct packed {
    logic [2:0] bit_cnt; // bit within the byte
    logic [6:0] shin; // bits of the byte so far
    logic op_done; // opcode byte already taken
    logic rd_act; // read-back running
    logic [1:0] rd_sel; // which mirror byte is read
    logic [7:0] shout; // outgoing byte, msb on the pin
    logic [7:0] byte_q; // completed byte
    logic phase; // byte event level
  } fscp_front_s;

  fscp_front_s q_r;
  fscp_front_s q_nxt;
  logic [7:0] full_byte;
  logic [7:0] pick;

  // next frame state
  always_comb begin
    q_nxt = q_r;
    full_byte = {q_r.shin, i_si};
    q_nxt.bit_cnt = q_r.bit_cnt + 3'h1;
    q_nxt.shout = {q_r.shout[6:0], 1'b0};
    q_nxt.shin = {q_r.shin[5:0], i_si};
    if (q_r.bit_cnt == BIT_LAST) begin
      // byte complete: hand it over by flipping the phase level
      q_nxt.byte_q = full_byte;
      q_nxt.phase = ~q_r.phase;
      if (!q_r.op_done) begin
        q_nxt.op_done = 1'b1;
        case (full_byte)
          OP_READ_LO: begin
            q_nxt.rd_act = 1'b1;
            q_nxt.rd_sel = 2'h0;
          end
          OP_READ_HI: begin
            q_nxt.rd_act = 1'b1;
            q_nxt.rd_sel = 2'h1;
          end
          OP_READ_CFG: begin
            q_nxt.rd_act = 1'b1;
            q_nxt.rd_sel = 2'h2;
          end
          default: begin
            q_nxt.rd_act = q_r.rd_act;
          end
        endcase
      end
    end
    // the mirror is quiet during a frame, so it may be read here directly
    case (q_nxt.rd_sel)
      2'h0: pick = lnk.mirror[7:0];
      2'h1: pick = lnk.mirror[15:8];
      default: pick = lnk.mirror[23:16];
    endcase
    // reload the outgoing byte on every byte boundary, repeating the read
    if ((q_r.bit_cnt == BIT_LAST) && q_nxt.rd_act) begin
      q_nxt.shout = pick;
    end
  end

  // frame state register, held clear between frames
  always_ff @(posedge i_sclk or posedge i_cs_n) begin
    if (i_cs_n) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign o_so = q_r.shout[7];
  assign o_so_oe = q_r.rd_act;
  assign lnk.rx_byte = q_r.byte_q;
  assign lnk.rx_phase = q_r.phase;
endmodule
`default_nettype wire

/* File: fscp_host_model.sv */
// host controller model driving the serial link
`timescale 1ns/1ps
`default_nettype none
module fscp_host_model (
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_si,
  input wire logic i_so
);
  // idle: clock parked low, chip deselected
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_si = 1'b0;
  end
  // one frame msb first; rx keeps the bits seen at edges 9 to 16
  task automatic frame(input int nb, input logic [31:0] tx, output logic [7:0] rx);
    rx = 8'h00;
    o_cs_n = 1'b0;
    #20;
    for (int k = 0; k < nb * 8; k++) begin
      o_si = tx[31 - k];
      #16;
      if (k >= 8 && k < 16) rx = {rx[6:0], i_so};
      o_sclk = 1'b1;
      #16 o_sclk = 1'b0;
    end
    // hold select past the last edge, then release and scramble data
    #16 o_cs_n = 1'b1;
    o_si = ~o_si;
    #80;
  endtask
endmodule
`default_nettype wire

/* File: fscp_flash_regs_tb.sv */
// self-checking bench for the status and configuration register bank
`timescale 1ns/1ps
`default_nettype none
module fscp_flash_regs_tb;
  import fscp_pkg::*;
  logic i_mclk, i_rst, sclk, cs_n, si, so, wp_n, done, ok, abrt, blk, req, wpa, qc, rf;
  logic [15:0] sw;
  logic [7:0] cw, rx, opc;
  logic [6:0] pct;
  logic [3:0] dd, dq, pv;
  logic [9:0] msk;
  logic [6:0] pt [4] = '{7'h50, 7'h28, 7'h64, 7'h3c};
  logic [7:0] sop [3] = '{8'h75, 8'hb0, 8'h75};
  logic [7:0] cop [3] = '{8'h7a, 8'h30, 8'h99};
  int failures, checked, cyc, nreq, n0, nq, nrf;
  fscp_flash_regs fscp_flash_regs_i (.i_mclk(i_mclk), .i_rst(i_rst), .i_sclk(sclk), .i_cs_n(cs_n), .i_si(si),
    .i_wp_n(wp_n), .i_busy(1'b0), .i_pe_done(done), .i_pe_ok(ok), .i_pe_abort(abrt), .i_pe_blocked(blk),
    .o_so(so), .o_so_oe(), .o_status_word(sw), .o_config_word(cw), .o_quad_io_enable(), .o_wp_pin_active(wpa),
    .o_hold_pin_active(), .o_array_guard_bits(), .o_protect_invert(), .o_secreg_lock(), .o_suspended(),
    .o_page_wrap_mask(msk), .o_drive_pct(pct), .o_dummy_dual(dd), .o_dummy_quad(dq), .o_pe_req(req),
    .o_pe_opcode(opc), .o_quad_cmd(qc), .o_cmd_refused(rf));
  fscp_host_model fscp_host_model_i (.o_sclk(sclk), .o_cs_n(cs_n), .o_si(si), .i_so(so));
  // core clock, 4 ns
  initial begin
    i_mclk = 1'b0;
    forever #2 i_mclk = ~i_mclk;
  end
  // hang guard and accepted-operation counter
  always @(posedge i_mclk) begin
    cyc++;
    if (req === 1'b1) nreq++;
    if (qc === 1'b1) nq++;
    if (rf === 1'b1) nrf++;
    if (cyc == 40000) begin
      failures++;
      wrap_up();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmd(input logic [7:0] op);
    fscp_host_model_i.frame(1, {op, 24'h0}, rx);
  endtask
  // write enable, then a full status and config write
  task automatic wr(input logic [23:0] d);
    cmd(OP_WR_ENABLE);
    fscp_host_model_i.frame(4, {OP_STAT_WRITE, d}, rx);
  endtask
  // one engine strobe {done, ok, abort, blocked}
  task automatic pe(input logic [3:0] v);
    @(posedge i_mclk);
    {done, ok, abrt, blk} <= v;
    @(posedge i_mclk);
    {done, ok, abrt, blk} <= 4'h0;
    repeat (4) @(posedge i_mclk);
  endtask
  task automatic pwr();
    @(posedge i_mclk);
    i_rst <= 1'b1;
    repeat (3) @(posedge i_mclk);
    i_rst <= 1'b0;
    repeat (4) @(posedge i_mclk);
  endtask
  task automatic wrap_up();
    if (failures == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    {i_rst, wp_n, done, ok, abrt, blk} = 6'h30;
    failures = 0;
    checked = 0;
    pwr();
    chk(sw, 16'h0000);
    chk({8'h0, cw}, 16'h0060);
    chk({9'h0, pct}, 16'h003c);
    chk({12'h0, dd, 4'h0} | {12'h0, dq}, 16'h0046);
    chk({6'h0, msk}, 16'h00ff);
    chk({15'h0, wpa}, 16'h0001);
    // quad opcode with quad enable clear is refused
    cmd(OP_QREAD_IO);
    chk({8'(nq), 8'(nrf)}, 16'h0001);
    fscp_host_model_i.frame(2, {OP_STAT_WRITE, 8'h80, 16'h0}, rx);
    chk(sw, 16'h0000);
    wr(24'h004a11);
    chk(sw, 16'h4a00);
    chk({15'h0, wpa}, 16'h0000);
    // quad opcode accepted once quad enable is set
    cmd(OP_QREAD_IO);
    chk({8'(nq), 8'(nrf)}, 16'h0102);
    chk({6'h0, msk}, 16'h03ff);
    chk({12'h0, dd, 4'h0} | {12'h0, dq}, 16'h008a);
    fscp_host_model_i.frame(2, {OP_READ_CFG, 24'h0}, rx);
    chk({8'h0, rx}, 16'h0011);
    // every drive code, locks written back as zero
    for (int c = 0; c < 4; c++) begin
      wr({16'h0000, 1'b0, 2'(c), 5'h0});
      chk(sw, 16'h0800);
      chk({9'h0, pct}, {9'h0, pt[c]});
      chk({8'h0, cw}, {9'h0, 2'(c), 5'h0});
    end
    wr(24'h800860);
    wp_n <= 1'b0;
    wr(24'h840860);
    chk(sw, 16'h0880);
    wp_n <= 1'b1;
    wr(24'h840860);
    chk(sw, 16'h0884);
    wr(24'h000960);
    wr(24'h000860);
    chk(sw, 16'h0900);
    pwr();
    chk(sw, 16'h0000);
    wr(24'h800160);
    wr(24'h000060);
    chk(sw, 16'h0180);
    for (int i = 0; i < 3; i++) begin
      cmd(sop[i]);
      chk(sw, 16'h8180);
      if (i == 2) cmd(OP_RESET_ARM);
      cmd(cop[i]);
      chk(sw, 16'h0180);
    end
    // failed, aborted, blocked each set; success clears
    foreach (pv[j]) begin
      if (j < 3) begin
        pe(4'h1 << (j + (j == 2)));
        chk(sw, 16'h0580);
        pe(4'hc);
        chk(sw, 16'h0180);
      end
    end
    n0 = nreq;
    cmd(OP_PROG);
    chk(16'(nreq - n0), 16'h0000);
    cmd(OP_WR_ENABLE);
    cmd(OP_PROG);
    chk(16'(nreq - n0), 16'h0001);
    chk({8'h0, opc}, 16'h0002);
    wrap_up();
  end
endmodule
`default_nettype wire
